// [rtl/branch_misc_opcode_decode.sv]
// Purpose: executes conditional, compare, decrement and misc opcodes
// Assumes: operand bytes arrive with the opcode; rd_data_i answers
//          rd_addr_o in the same cycle
// Notes:   input port bytes are read through a stabilised copy
// Operation
// - opcode 30 jumps when bit is zero; three bytes, two cycles
// - opcode 10 jumps when bit is one and clears it
// - opcode 73 loads pc with accumulator plus data pointer
// - opcode 60 jumps when accumulator is zero; two bytes
// - opcode 70 jumps when accumulator is nonzero; two bytes
// - opcode B5 jumps when accumulator differs from direct byte
// - opcode B4 jumps when accumulator differs from immediate
// - opcodes B8-BF jump when register differs from immediate
// - opcodes B6-B7 jump when indirect byte differs from immediate
// - opcodes D8-DF decrement register, jump if nonzero; three bytes
// - opcode D5 decrements direct byte, jumps if nonzero
// - opcode A5 is program store or trap by extension nibble
// - register number comes from the opcode's low three bits, low bit only for B6-B7
// - absolute opcodes give top three of eleven address bits
// - bit tests of raw input pins may be evaluated wrongly
// - memory, special registers and output bits evaluate correctly
// - a steady input pin yields a correct branch decision
// - opcode 20 jumps when bit is one; three bytes, two cycles
// - absolute call and jump opcodes are two bytes, two cycles
`timescale 1ns/1ps
module branch_misc_opcode_decode (
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic        op_valid_i,
	input  wire logic [7:0]  opcode_i,
	input  wire logic [7:0]  operand1_i,
	input  wire logic [7:0]  operand2_i,
	input  wire logic [15:0] pc_i,
	input  wire logic [7:0]  acc_i,
	input  wire logic [15:0] data_pointer_i,
	input  wire logic [1:0]  bank_i,
	input  wire logic [7:0]  extension_select_reg_i,
	input  wire logic [7:0]  rd_data_i,
	input  wire logic [7:0]  pins_i,
	output logic             ready_o,
	output logic      [7:0]  rd_addr_o,
	output logic             done_o,
	output logic             branch_o,
	output logic      [15:0] pc_o,
	output logic             call_o,
	output logic      [15:0] ret_pc_o,
	output logic             wr_en_o,
	output logic      [7:0]  wr_addr_o,
	output logic      [7:0]  wr_data_o,
	output logic             pm_we_o,
	output logic      [15:0] pm_addr_o,
	output logic      [7:0]  pm_data_o,
	output logic             data_pointer_inc_o,
	output logic             trap_o,
	output logic             unknown_o
);
	typedef enum logic [1:0] {
		st_idle,
		st_fetch,
		st_exec
	} exec_state_e;

	exec_state_e state;
	logic [7:0]  op;
	logic [7:0]  opnd1;
	logic [7:0]  opnd2;
	logic [15:0] pc;
	logic [7:0]  acc;
	logic [15:0] data_ptr;
	logic [1:0]  bank;
	logic [7:0]  ext_sel;
	logic [7:0]  pins_stable;
	logic [3:0]  cls;
	logic [7:0]  val;
	logic        bitv;
	logic [7:0]  dec;
	logic [7:0]  rel;
	logic [15:0] fall_pc;
	logic [15:0] rel_pc;
	logic        next_take;
	logic [15:0] next_pc;
	logic        next_wr;
	logic [7:0]  next_wdata;

	////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic [3:0] op_class(input logic [7:0] o);
		logic [3:0] c;
		c = branch_decode_pkg::CL_NONE;
		if (o == branch_decode_pkg::OP_BIT_SET) begin
			c = branch_decode_pkg::CL_BIT_SET;
		end else if (o == branch_decode_pkg::OP_BIT_CLR) begin
			c = branch_decode_pkg::CL_BIT_CLR;
		end else if (o == branch_decode_pkg::OP_BSET_CLR) begin
			c = branch_decode_pkg::CL_BSET_CLR;
		end else if (o == branch_decode_pkg::OP_JMPI) begin
			c = branch_decode_pkg::CL_JMPI;
		end else if (o == branch_decode_pkg::OP_ACC_ZERO) begin
			c = branch_decode_pkg::CL_ACC_ZERO;
		end else if (o == branch_decode_pkg::OP_JNZ) begin
			c = branch_decode_pkg::CL_JNZ;
		end else if (o == branch_decode_pkg::OP_CJ_DIR) begin
			c = branch_decode_pkg::CL_CJ_DIR;
		end else if (o == branch_decode_pkg::OP_CJ_IMM) begin
			c = branch_decode_pkg::CL_CJ_IMM;
		end else if (o[7:3] == branch_decode_pkg::OP_CJ_REG_HI) begin
			c = branch_decode_pkg::CL_CJ_REG;
		end else if (o[7:1] == branch_decode_pkg::OP_CJ_IND_HI) begin
			c = branch_decode_pkg::CL_CJ_IND;
		end else if (o[7:3] == branch_decode_pkg::OP_DJ_REG_HI) begin
			c = branch_decode_pkg::CL_DJ_REG;
		end else if (o == branch_decode_pkg::OP_DJ_DIR) begin
			c = branch_decode_pkg::CL_DJ_DIR;
		end else if (o == branch_decode_pkg::OP_EXT) begin
			c = branch_decode_pkg::CL_EXT;
		end else if (o[4:0] == branch_decode_pkg::OP_JUMP_LO) begin
			c = branch_decode_pkg::CL_ABS;
		end else if (o[4:0] == branch_decode_pkg::OP_CALL_LO) begin
			c = branch_decode_pkg::CL_ABS;
		end else if (o == branch_decode_pkg::OP_NOP) begin
			c = branch_decode_pkg::CL_NOP;
		end
		return c;
	endfunction

	// byte length per class
	function automatic logic [1:0] op_len(input logic [3:0] c);
		logic [1:0] l;
		l = branch_decode_pkg::LEN3;
		case (c)
			branch_decode_pkg::CL_JMPI,
			branch_decode_pkg::CL_EXT,
			branch_decode_pkg::CL_NOP,
			branch_decode_pkg::CL_NONE: l = branch_decode_pkg::LEN1;
			branch_decode_pkg::CL_ACC_ZERO,
			branch_decode_pkg::CL_JNZ,
			branch_decode_pkg::CL_ABS: l = branch_decode_pkg::LEN2;
			default: l = branch_decode_pkg::LEN3;
		endcase
		return l;
	endfunction

	// working register address in the selected bank
	function automatic logic [7:0] reg_addr(input logic [1:0] b,
		input logic [2:0] r);
		return {3'b000, b, r};
	endfunction

	// byte that holds an addressable bit
	function automatic logic [7:0] bit_byte(input logic [7:0] b);
		logic [7:0] a;
		a = {b[7:3], 3'b000};
		if (!b[7]) begin
			a = 8'(branch_decode_pkg::BIT_RAM_BASE + {4'h0, b[6:3]});
		end
		return a;
	endfunction

	// first read address of each class
	function automatic logic [7:0] first_addr(input logic [3:0] c,
		input logic [7:0] o, input logic [7:0] b1, input logic [1:0] b);
		logic [7:0] a;
		a = b1;
		case (c)
			branch_decode_pkg::CL_BIT_SET,
			branch_decode_pkg::CL_BIT_CLR,
			branch_decode_pkg::CL_BSET_CLR: a = bit_byte(b1);
			branch_decode_pkg::CL_CJ_REG,
			branch_decode_pkg::CL_DJ_REG: a = reg_addr(b, o[2:0]);
			branch_decode_pkg::CL_CJ_IND: a = reg_addr(b, {2'b00, o[0]});
			default: a = b1;
		endcase
		return a;
	endfunction

	////////////////////////////////////////////////////////////////////
	// input port stabiliser and target adder

	pin_stabilizer u_pins (
		.mclk_i (mclk_i),
		.srst_i (srst_i),
		.pins_i (pins_i),
		.pins_o (pins_stable)
	);

	rel_target u_target (
		.pc_i      (pc),
		.len_i     (op_len(cls)),
		.rel_i     (rel),
		.next_pc_o (fall_pc),
		.target_o  (rel_pc)
	);

	assign cls = op_class(op);

	////////////////////////////////////////////////////////////////////
	// instruction capture and sequencing

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			state   <= st_idle;
			ready_o <= 1'b1;
		end else begin
			case (state)
				st_idle: begin
					if (op_valid_i) begin
						state   <= st_fetch;
						ready_o <= 1'b0;
					end
				end
				st_fetch: begin
					if (cls == branch_decode_pkg::CL_NOP || cls == branch_decode_pkg::CL_NONE) begin
						state   <= st_idle;
						ready_o <= 1'b1;
					end else if (cls == branch_decode_pkg::CL_EXT
						&& ext_sel[7:4] != branch_decode_pkg::EXT_STORE) begin
						state   <= st_idle;
						ready_o <= 1'b1;
					end else begin
						state <= st_exec;
					end
				end
				default: begin
					state   <= st_idle;
					ready_o <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			op      <= 8'h00;
			opnd1   <= 8'h00;
			opnd2   <= 8'h00;
			pc      <= 16'h0000;
			acc     <= 8'h00;
			data_ptr <= 16'h0000;
			bank    <= 2'b00;
			ext_sel <= 8'h00;
		end else if (state == st_idle && op_valid_i) begin
			op      <= opcode_i;
			opnd1   <= operand1_i;
			opnd2   <= operand2_i;
			pc      <= pc_i;
			acc     <= acc_i;
			data_ptr <= data_pointer_i;
			bank    <= bank_i;
			ext_sel <= extension_select_reg_i;
		end
	end

	// read address: operand, bit byte or register, then pointer target for indirect
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rd_addr_o <= 8'h00;
		end else if (state == st_idle && op_valid_i) begin
			rd_addr_o <= first_addr(op_class(opcode_i), opcode_i, operand1_i, bank_i);
		end else if (state == st_fetch && cls == branch_decode_pkg::CL_CJ_IND) begin
			rd_addr_o <= rd_data_i;
		end
	end

	////////////////////////////////////////////////////////////////////
	// execute: operand value, decision and target

	// one-hot mask of the addressed bit
	function automatic logic [7:0] bit_mask(input logic [2:0] n);
		return 8'(branch_decode_pkg::ONE_BYTE << n);
	endfunction

	always_comb begin
		// input port bytes come from the stabilised copy
		val = rd_data_i;
		if (rd_addr_o == branch_decode_pkg::PIN_PORT_ADR) begin
			val = pins_stable;
		end
		bitv = val[opnd1[2:0]];
		dec  = 8'(val - branch_decode_pkg::ONE_BYTE);
		rel  = (op_len(cls) == branch_decode_pkg::LEN2) ? opnd1 : opnd2;
		next_take  = 1'b0;
		next_wr    = 1'b0;
		next_wdata = val;
		case (cls)
			branch_decode_pkg::CL_BIT_SET: next_take = bitv;
			branch_decode_pkg::CL_BIT_CLR: next_take = !bitv;
			branch_decode_pkg::CL_BSET_CLR: begin
				next_take  = bitv;
				next_wr    = bitv;
				next_wdata = val & ~bit_mask(opnd1[2:0]);
			end
			branch_decode_pkg::CL_JMPI: next_take = 1'b1;
			branch_decode_pkg::CL_ACC_ZERO: next_take = (acc == 8'h00);
			branch_decode_pkg::CL_JNZ: next_take = (acc != 8'h00);
			branch_decode_pkg::CL_CJ_DIR: next_take = (acc != val);
			branch_decode_pkg::CL_CJ_IMM: next_take = (acc != opnd1);
			branch_decode_pkg::CL_CJ_REG: next_take = (val != opnd1);
			branch_decode_pkg::CL_CJ_IND: next_take = (val != opnd1);
			branch_decode_pkg::CL_DJ_REG,
			branch_decode_pkg::CL_DJ_DIR: begin
				next_take  = (dec != 8'h00);
				next_wr    = 1'b1;
				next_wdata = dec;
			end
			branch_decode_pkg::CL_ABS: next_take = 1'b1;
			default: next_take = 1'b0;
		endcase
		next_pc = fall_pc;
		if (next_take) begin
			next_pc = rel_pc;
			if (cls == branch_decode_pkg::CL_JMPI) begin
				next_pc = 16'(data_ptr + {8'h00, acc});
			end else if (cls == branch_decode_pkg::CL_ABS) begin
				next_pc = {fall_pc[15:11], op[7:5], opnd1};
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// result outputs

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			done_o    <= 1'b0;
			branch_o  <= 1'b0;
			pc_o      <= 16'h0000;
			call_o    <= 1'b0;
			ret_pc_o  <= 16'h0000;
			unknown_o <= 1'b0;
		end else begin
			done_o    <= 1'b0;
			branch_o  <= 1'b0;
			call_o    <= 1'b0;
			unknown_o <= 1'b0;
			if (state == st_exec) begin
				done_o   <= 1'b1;
				branch_o <= next_take;
				pc_o     <= next_pc;
				call_o   <= (cls == branch_decode_pkg::CL_ABS) && op[4];
				ret_pc_o <= fall_pc;
			end else if (state == st_fetch && (cls == branch_decode_pkg::CL_NOP
				|| cls == branch_decode_pkg::CL_NONE
				|| (cls == branch_decode_pkg::CL_EXT
				&& ext_sel[7:4] != branch_decode_pkg::EXT_STORE))) begin
				done_o    <= 1'b1;
				pc_o      <= fall_pc;
				ret_pc_o  <= fall_pc;
				unknown_o <= (cls == branch_decode_pkg::CL_NONE);
			end
		end
	end

	// data memory write-back for clear and decrement
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			wr_en_o   <= 1'b0;
			wr_addr_o <= 8'h00;
			wr_data_o <= 8'h00;
		end else begin
			wr_en_o <= 1'b0;
			if (state == st_exec && next_wr) begin
				wr_en_o   <= 1'b1;
				wr_addr_o <= rd_addr_o;
				wr_data_o <= next_wdata;
			end
		end
	end

	// extension opcode: program store or trap
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pm_we_o            <= 1'b0;
			pm_addr_o          <= 16'h0000;
			pm_data_o          <= 8'h00;
			data_pointer_inc_o <= 1'b0;
			trap_o             <= 1'b0;
		end else begin
			pm_we_o            <= 1'b0;
			data_pointer_inc_o <= 1'b0;
			trap_o             <= 1'b0;
			if (cls == branch_decode_pkg::CL_EXT) begin
				if (state == st_exec) begin
					pm_we_o            <= 1'b1;
					pm_addr_o          <= data_ptr;
					pm_data_o          <= acc;
					data_pointer_inc_o <= 1'b1;
				end else if (state == st_fetch
					&& ext_sel[7:4] != branch_decode_pkg::EXT_STORE) begin
					trap_o <= 1'b1;
				end
			end
		end
	end
endmodule

// [rtl/branch_decode_pkg.sv]
// Purpose: shared constants of the branch and misc opcode executor
// Assumes: 8-bit core, 16-bit program counter
// Notes:   opcode codes, operand classes, address layout
package branch_decode_pkg;
	localparam logic [7:0] OP_NOP       = 8'h00;
	localparam logic [7:0] OP_BSET_CLR  = 8'h10;
	localparam logic [7:0] OP_BIT_SET   = 8'h20;
	localparam logic [7:0] OP_BIT_CLR   = 8'h30;
	localparam logic [7:0] OP_ACC_ZERO  = 8'h60;
	localparam logic [7:0] OP_JNZ       = 8'h70;
	localparam logic [7:0] OP_JMPI      = 8'h73;
	localparam logic [7:0] OP_EXT       = 8'hA5;
	localparam logic [7:0] OP_CJ_IMM    = 8'hB4;
	localparam logic [7:0] OP_CJ_DIR    = 8'hB5;
	localparam logic [7:0] OP_DJ_DIR    = 8'hD5;
	localparam logic [6:0] OP_CJ_IND_HI = 7'h5B;
	localparam logic [4:0] OP_CJ_REG_HI = 5'h17;
	localparam logic [4:0] OP_DJ_REG_HI = 5'h1B;
	localparam logic [4:0] OP_JUMP_LO   = 5'h01;
	localparam logic [4:0] OP_CALL_LO   = 5'h11;
	localparam logic [3:0] EXT_STORE    = 4'h1;
	localparam logic [7:0] BIT_RAM_BASE = 8'h20;
	localparam logic [7:0] PIN_PORT_ADR = 8'h80;
	localparam logic [7:0] ONE_BYTE     = 8'h01;
	localparam logic [1:0] LEN1         = 2'h1;
	localparam logic [1:0] LEN2         = 2'h2;
	localparam logic [1:0] LEN3         = 2'h3;
	localparam logic [3:0] CL_NONE      = 4'h0;
	localparam logic [3:0] CL_BIT_SET   = 4'h1;
	localparam logic [3:0] CL_BIT_CLR   = 4'h2;
	localparam logic [3:0] CL_BSET_CLR  = 4'h3;
	localparam logic [3:0] CL_JMPI      = 4'h4;
	localparam logic [3:0] CL_ACC_ZERO  = 4'h5;
	localparam logic [3:0] CL_JNZ       = 4'h6;
	localparam logic [3:0] CL_CJ_DIR    = 4'h7;
	localparam logic [3:0] CL_CJ_IMM    = 4'h8;
	localparam logic [3:0] CL_CJ_REG    = 4'h9;
	localparam logic [3:0] CL_CJ_IND    = 4'hA;
	localparam logic [3:0] CL_DJ_REG    = 4'hB;
	localparam logic [3:0] CL_DJ_DIR    = 4'hC;
	localparam logic [3:0] CL_EXT       = 4'hD;
	localparam logic [3:0] CL_ABS       = 4'hE;
	localparam logic [3:0] CL_NOP       = 4'hF;
endpackage

// [rtl/pin_stabilizer.sv]
// Purpose: three-stage input pin synchroniser with agreement filter
// Assumes: pins are asynchronous to mclk_i
// Notes:   a bit changes only once stages two and three agree
`timescale 1ns/1ps
module pin_stabilizer (
	input  wire logic       mclk_i,
	input  wire logic       srst_i,
	input  wire logic [7:0] pins_i,
	output logic      [7:0] pins_o
);
	logic [7:0] stage1;
	logic [7:0] stage2;
	logic [7:0] stage3;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			stage1 <= 8'h00;
			stage2 <= 8'h00;
			stage3 <= 8'h00;
		end else begin
			stage1 <= pins_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	for (genvar i = 0; i < 8; i++) begin : g_bit
		always_ff @(posedge mclk_i) begin
			if (srst_i) begin
				pins_o[i] <= 1'b0;
			end else if (stage2[i] == stage3[i]) begin
				pins_o[i] <= stage3[i];
			end
		end
	end
endmodule

// [rtl/rel_target.sv]
// Purpose: relative branch target and fall-through address
// Assumes: pc_i is the address of the opcode byte
// Notes:   purely combinational
`timescale 1ns/1ps
module rel_target (
	input  wire logic [15:0] pc_i,
	input  wire logic [1:0]  len_i,
	input  wire logic [7:0]  rel_i,
	output logic      [15:0] next_pc_o,
	output logic      [15:0] target_o
);
	// offset is sign-extended and added to the following address
	assign next_pc_o = 16'(pc_i + {14'h0000, len_i});
	assign target_o  = 16'(next_pc_o + {{8{rel_i[7]}}, rel_i});
endmodule

// [tb/branch_misc_opcode_decode_props.sv]
// Purpose: checker for branch and misc opcode execution at the top ports
// Assumes: inputs are latched at the taking edge
// Notes:   attached by bind after the module
`timescale 1ns/1ps
module branch_misc_opcode_decode_props (
	input wire logic        mclk_i,
	input wire logic        srst_i,
	input wire logic        op_valid_i,
	input wire logic [7:0]  opcode_i,
	input wire logic [7:0]  operand1_i,
	input wire logic [15:0] pc_i,
	input wire logic [7:0]  acc_i,
	input wire logic [15:0] data_pointer_i,
	input wire logic [7:0]  extension_select_reg_i,
	input wire logic        ready_o,
	input wire logic        done_o,
	input wire logic        branch_o,
	input wire logic [15:0] pc_o,
	input wire logic        call_o,
	input wire logic        pm_we_o,
	input wire logic [15:0] pm_addr_o,
	input wire logic [7:0]  pm_data_o,
	input wire logic        data_pointer_inc_o,
	input wire logic        trap_o
);
	logic take;
	assign take = op_valid_i && ready_o;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	////////////////////////////////////////////////////////////////
	property p_busy;
		take && opcode_i == 8'h30 |=> !ready_o [*2] ##1 (done_o && ready_o);
	endproperty
	a_busy: assert property (p_busy) else $error("bit test timing wrong");
	property p_jz;
		take && opcode_i == 8'h60 |-> ##3 (done_o && branch_o == ($past(acc_i, 3) == 8'h00));
	endproperty
	a_jz: assert property (p_jz) else $error("zero test decision wrong");
	property p_jnz;
		take && opcode_i == 8'h70 |-> ##3 (done_o && branch_o == ($past(acc_i, 3) != 8'h00));
	endproperty
	a_jnz: assert property (p_jnz) else $error("nonzero test decision wrong");
	property p_jmpi;
		take && opcode_i == 8'h73 |-> ##3 (done_o && pc_o == $past(data_pointer_i, 3) + {8'h00, $past(acc_i, 3)});
	endproperty
	a_jmpi: assert property (p_jmpi) else $error("indirect jump target wrong");
	property p_cjimm;
		take && opcode_i == 8'hB4 |-> ##3 (done_o && branch_o == ($past(acc_i, 3) != $past(operand1_i, 3)));
	endproperty
	a_cjimm: assert property (p_cjimm) else $error("immediate compare wrong");
	property p_rel;
		take && opcode_i == 8'h60 && acc_i == 8'h00 |-> ##3
			pc_o == $past(pc_i, 3) + 16'h0002 + {{8{$past(operand1_i[7], 3)}}, $past(operand1_i, 3)};
	endproperty
	a_rel: assert property (p_rel) else $error("relative target wrong");
	property p_trap;
		take && opcode_i == 8'hA5 && extension_select_reg_i[7:4] != 4'h1 |-> ##2 (trap_o && done_o && !pm_we_o);
	endproperty
	a_trap: assert property (p_trap) else $error("break trap missing");
	property p_store;
		take && opcode_i == 8'hA5 && extension_select_reg_i[7:4] == 4'h1 |-> ##3
			(pm_we_o && data_pointer_inc_o && pm_addr_o == $past(data_pointer_i, 3) && pm_data_o == $past(acc_i, 3));
	endproperty
	a_store: assert property (p_store) else $error("program store wrong");
	property p_abs;
		take && opcode_i[4:0] == 5'h01 |-> ##3
			(done_o && !call_o && pc_o[10:0] == {$past(opcode_i[7:5], 3), $past(operand1_i, 3)});
	endproperty
	a_abs: assert property (p_abs) else $error("absolute jump target wrong");
endmodule
bind branch_misc_opcode_decode branch_misc_opcode_decode_props i_props (.mclk_i, .srst_i, .op_valid_i,
	.opcode_i, .operand1_i, .pc_i, .acc_i, .data_pointer_i, .extension_select_reg_i, .ready_o, .done_o,
	.branch_o, .pc_o, .call_o, .pm_we_o, .pm_addr_o, .pm_data_o, .data_pointer_inc_o, .trap_o);

// [tb/data_mem_model.sv]
// Purpose: internal data memory answering the block's reads
// Assumes: read data follows the address in the same cycle
// Notes:   bench preloads cells directly
`timescale 1ns/1ps
module data_mem_model (
	input  wire logic       mclk_i,
	input  wire logic [7:0] rd_addr_i,
	output logic      [7:0] rd_data_o,
	input  wire logic       wr_en_i,
	input  wire logic [7:0] wr_addr_i,
	input  wire logic [7:0] wr_data_i
);
	logic [7:0] mem [0:255];
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'h00;
	end
	assign rd_data_o = mem[rd_addr_i];
	always @(posedge mclk_i) begin
		if (wr_en_i) mem[wr_addr_i] <= wr_data_i;
	end
endmodule

// [tb/branch_misc_opcode_decode_tb.sv]
// Purpose: self-checking bench of the branch and misc opcode block
// Assumes: one instruction at a time, driven at the falling edge
// Notes:   data memory model answers reads
`timescale 1ns/1ps
module branch_misc_opcode_decode_tb;
	logic mclk_i, srst_i, op_valid_i, ready_o, done_o, branch_o, call_o, wr_en_o, pm_we_o, data_pointer_inc_o, trap_o;
	logic [7:0] opcode_i, operand1_i, operand2_i, acc_i, extension_select_reg_i, rd_data_i, pins_i;
	logic [7:0] rd_addr_o, wr_addr_o, wr_data_o, pm_data_o;
	logic [15:0] pc_i, data_pointer_i, pc_o, ret_pc_o, pm_addr_o;
	logic [1:0] bank_i;
	logic unknown_o, r_br, r_call, r_trap, r_pmwe, r_inc, r_wr, r_unk;
	logic [15:0] r_pc, r_ret;
	int num_errors = 0, samples_checked = 0, r_n;
	branch_misc_opcode_decode i_dut (.mclk_i, .srst_i, .op_valid_i, .opcode_i, .operand1_i, .operand2_i,
		.pc_i, .acc_i, .data_pointer_i, .bank_i, .extension_select_reg_i, .rd_data_i, .pins_i, .ready_o,
		.rd_addr_o, .done_o, .branch_o, .pc_o, .call_o, .ret_pc_o, .wr_en_o, .wr_addr_o, .wr_data_o,
		.pm_we_o, .pm_addr_o, .pm_data_o, .data_pointer_inc_o, .trap_o, .unknown_o);
	data_mem_model i_mem (.mclk_i, .rd_addr_i(rd_addr_o), .rd_data_o(rd_data_i), .wr_en_i(wr_en_o),
		.wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o));
	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic run_op(input logic [7:0] op, o1, o2, a, input logic [15:0] pc, dp, input int lat);
		opcode_i = op; operand1_i = o1; operand2_i = o2; acc_i = a; pc_i = pc; data_pointer_i = dp;
		op_valid_i = 1'b1;
		@(negedge mclk_i);
		op_valid_i = 1'b0;
		r_n = 1;
		while (r_n < 8 && done_o !== 1'b1) begin
			@(negedge mclk_i);
			r_n++;
		end
		chk("latency", 16'(r_n), 16'(lat));
		r_br = branch_o; r_pc = pc_o; r_call = call_o; r_trap = trap_o; r_pmwe = pm_we_o;
		r_inc = data_pointer_inc_o; r_wr = wr_en_o; r_ret = ret_pc_o; r_unk = unknown_o;
		@(negedge mclk_i);
	endtask
	task automatic br_chk(input string nm, input logic br, input logic [15:0] pc);
		chk(nm, {15'h0, r_br}, {15'h0, br});
		chk(nm, r_pc, pc);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_bit;
		i_mem.mem[8'h20] = 8'h20;
		run_op(8'h20, 8'h05, 8'h10, 8'h00, 16'h0100, 16'h0, 3); br_chk("set bit", 1'b1, 16'h0113);
		run_op(8'h30, 8'h05, 8'h10, 8'h00, 16'h0100, 16'h0, 3); br_chk("clr bit", 1'b0, 16'h0103);
		run_op(8'h30, 8'h06, 8'h10, 8'h00, 16'h0100, 16'h0, 3); br_chk("clr bit2", 1'b1, 16'h0113);
		run_op(8'h10, 8'h05, 8'hFE, 8'h00, 16'h0100, 16'h0, 3); br_chk("set clr", 1'b1, 16'h0101);
		chk("bit cleared", {8'h0, i_mem.mem[8'h20]}, 16'h0000);
		run_op(8'h10, 8'h05, 8'hFE, 8'h00, 16'h0100, 16'h0, 3); br_chk("set clr2", 1'b0, 16'h0103);
		chk("no write", {15'h0, r_wr}, 16'h0000);
		$display("bit test done");
	endtask
	task automatic t_acc;
		run_op(8'h60, 8'hF0, 8'h00, 8'h00, 16'h0200, 16'h0, 3); br_chk("acc zero", 1'b1, 16'h01F2);
		run_op(8'h60, 8'hF0, 8'h00, 8'h80, 16'h0200, 16'h0, 3); br_chk("acc zero2", 1'b0, 16'h0202);
		run_op(8'h70, 8'h7F, 8'h00, 8'h80, 16'h0200, 16'h0, 3); br_chk("acc nz", 1'b1, 16'h0281);
		run_op(8'h70, 8'h7F, 8'h00, 8'h00, 16'h0200, 16'h0, 3); br_chk("acc nz2", 1'b0, 16'h0202);
		run_op(8'h73, 8'h00, 8'h00, 8'hFF, 16'h0200, 16'h1F02, 3); chk("indirect", r_pc, 16'h2001);
		$display("accumulator test done");
	endtask
	task automatic t_cmp;
		i_mem.mem[8'h40] = 8'h33;
		run_op(8'hB5, 8'h40, 8'h08, 8'h33, 16'h0300, 16'h0, 3); br_chk("cmp dir", 1'b0, 16'h0303);
		run_op(8'hB5, 8'h40, 8'h08, 8'h34, 16'h0300, 16'h0, 3); br_chk("cmp dir2", 1'b1, 16'h030B);
		run_op(8'hB4, 8'h55, 8'h08, 8'h55, 16'h0300, 16'h0, 3); br_chk("cmp imm", 1'b0, 16'h0303);
		run_op(8'hB4, 8'h56, 8'h08, 8'h55, 16'h0300, 16'h0, 3); br_chk("cmp imm2", 1'b1, 16'h030B);
		bank_i = 2'h1;
		for (int r = 0; r < 8; r++) begin
			i_mem.mem[8 + r] = 8'(8'h10 + r);
			run_op(8'(8'hB8 + r), 8'(8'h10 + r + r % 2), 8'h04, 8'h00, 16'h0300, 16'h0, 3);
			br_chk("cmp reg", 1'(r % 2), (r % 2) ? 16'h0307 : 16'h0303);
		end
		i_mem.mem[8'h10] = 8'h77;
		i_mem.mem[8'h11] = 8'h00;
		run_op(8'hB6, 8'h77, 8'h04, 8'h00, 16'h0300, 16'h0, 3); br_chk("cmp ind", 1'b0, 16'h0303);
		run_op(8'hB7, 8'h77, 8'h04, 8'h00, 16'h0300, 16'h0, 3); br_chk("cmp ind2", 1'b1, 16'h0307);
		$display("compare test done");
	endtask
	task automatic t_dec;
		bank_i = 2'h2;
		for (int r = 0; r < 8; r++) begin
			i_mem.mem[8'h10 + r] = 8'(r);
			run_op(8'(8'hD8 + r), 8'h00, 8'h04, 8'h00, 16'h0400, 16'h0, 3);
			br_chk("dec reg", r != 1, (r != 1) ? 16'h0407 : 16'h0403);
			chk("dec reg val", {8'h0, i_mem.mem[8'h10 + r]}, {8'h0, 8'(r - 1)});
		end
		i_mem.mem[8'h60] = 8'h01;
		run_op(8'hD5, 8'h60, 8'h04, 8'h00, 16'h0400, 16'h0, 3); br_chk("dec dir", 1'b0, 16'h0403);
		chk("dec dir val", {8'h0, i_mem.mem[8'h60]}, 16'h0000);
		$display("decrement test done");
	endtask
	task automatic t_ext;
		extension_select_reg_i = 8'h10;
		run_op(8'hA5, 8'h00, 8'h00, 8'h5A, 16'h0600, 16'h1234, 3);
		chk("store", {14'h0, r_pmwe, r_inc}, 16'h0003);
		chk("store addr", pm_addr_o, 16'h1234);
		chk("store data", {8'h0, pm_data_o}, 16'h005A);
		extension_select_reg_i = 8'h20;
		run_op(8'hA5, 8'h00, 8'h00, 8'h5A, 16'h0600, 16'h1234, 2);
		chk("trap", {14'h0, r_trap, r_pmwe}, 16'h0002);
		$display("extension test done");
	endtask
	task automatic t_abs;
		run_op(8'hE1, 8'h34, 8'h00, 8'h00, 16'h1800, 16'h0, 3); chk("abs jump", r_pc, 16'h1F34);
		chk("abs jump call", {15'h0, r_call}, 16'h0000);
		run_op(8'h51, 8'h78, 8'h00, 8'h00, 16'h1800, 16'h0, 3); chk("abs call", r_pc, 16'h1A78);
		chk("abs call ret", {r_ret[14:0], r_call}, 16'h3005);
		$display("absolute test done");
	endtask
	task automatic t_pin;
		run_op(8'h20, 8'h80, 8'h10, 8'h00, 16'h0500, 16'h0, 3); br_chk("pin bit", 1'b1, 16'h0513);
		run_op(8'h20, 8'h81, 8'h10, 8'h00, 16'h0500, 16'h0, 3); br_chk("pin bit2", 1'b0, 16'h0503);
		run_op(8'hB5, 8'h80, 8'h10, 8'h01, 16'h0500, 16'h0, 3); br_chk("pin byte", 1'b0, 16'h0503);
		i_mem.mem[8'h21] = {7'h00, pins_i[0]};
		run_op(8'h20, 8'h08, 8'h10, 8'h00, 16'h0500, 16'h0, 3); br_chk("pin copy", 1'b1, 16'h0513);
		pins_i = 8'h02;
		repeat (5) @(negedge mclk_i);
		run_op(8'h20, 8'h81, 8'h10, 8'h00, 16'h0500, 16'h0, 3); br_chk("pin bit3", 1'b1, 16'h0513);
		run_op(8'h30, 8'h80, 8'h10, 8'h00, 16'h0500, 16'h0, 3); br_chk("pin bit4", 1'b1, 16'h0513);
		$display("pin test done");
	endtask
	task automatic t_misc;
		run_op(8'h00, 8'h00, 8'h00, 8'h00, 16'h0700, 16'h0, 2); chk("nop", {r_unk, r_pc[14:0]}, 16'h0701);
		run_op(8'hA4, 8'h00, 8'h00, 8'h00, 16'h0700, 16'h0, 2); chk("unknown", {r_unk, r_pc[14:0]}, 16'h8701);
		$display("misc test done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		srst_i = 1'b1; op_valid_i = 1'b0; opcode_i = 8'h00; operand1_i = 8'h00; operand2_i = 8'h00;
		pc_i = 16'h0; acc_i = 8'h00; data_pointer_i = 16'h0; bank_i = 2'h0;
		extension_select_reg_i = 8'h00; pins_i = 8'h01;
		repeat (3) @(negedge mclk_i);
		srst_i = 1'b0;
		t_bit;
		t_acc;
		t_cmp;
		t_dec;
		t_ext;
		t_abs;
		t_pin;
		t_misc;
		final_report;
	end
	initial begin
		repeat (2000) @(posedge mclk_i);
		num_errors++;
		final_report;
	end
endmodule
